// ---- include/dmx_limit_regs.vh ----
// Register map, field positions, reset values and timing counts
`ifndef DMX_LIMIT_REGS_VH
`define DMX_LIMIT_REGS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_MODE 8'h00
`define OFS_STATUS 8'h04
`define OFS_EDIT_SEL 8'h08
`define OFS_EDIT_KEY 8'h0C
`define OFS_EDIT_VALUE 8'h10
`define OFS_PARAM_BASE 8'h20

// ----------------------------------------
// Fields
// ----------------------------------------
`define MODE_RESCALE_LSB 0
`define MODE_BYTE_LSB 4
`define KEY_COARSE_DEC 0
`define KEY_FINE_DEC 1
`define KEY_FINE_INC 2
`define KEY_COARSE_INC 3
`define KEY_ACCEPT 4

// ----------------------------------------
// Reset values and steps
// ----------------------------------------
`define LOWER_RESET 16'h0000
`define UPPER_RESET 16'hFFFF
`define HOME_RESET 16'h8000
`define MODE_RESET 8'h00
`define FINE_STEP 16'h0001
`define COARSE_STEP 16'h0100

// ----------------------------------------
// Channel levels
// ----------------------------------------
`define LVL_PAN_MIN_LO 8'h33
`define LVL_PAN_MAX_LO 8'h3F
`define LVL_TILT_MIN_LO 8'h4D
`define LVL_TILT_MAX_LO 8'h59
`define LVL_FOCUS_MIN_LO 8'h66
`define LVL_FOCUS_MAX_LO 8'h73
`define LVL_FOCUS_MAX_HI 8'h7F
`define LVL_RECAL_FOCUS_LO 8'h8C
`define LVL_RECAL_FOCUS_HI 8'h98
`define LVL_NORMAL_HI 8'h09
`define LVL_RESET 8'h82
`define LVL_ACTIVATE_LO 8'hE6

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLOCK_HZ 20000000
`define HOLD_TIME_MS 1000
`define HOLD_CYCLES ((`CLOCK_HZ / 1000) * `HOLD_TIME_MS)

`endif

// ---- rtl/dmx_axis_limit_command_decoder.v ----
// DMX control/activate command decoder with per-axis soft limits
`include "dmx_limit_regs.vh"

module dmx_axis_limit_command_decoder #(
	parameter HOLD_CYCLES = `HOLD_CYCLES,
	parameter AXES = 3
) (
	// Clock and reset
	input wire clock_i,
	input wire rst_b_i,
	// DMX channel levels from the receiver
	input wire [7:0] control_level_i,
	input wire [7:0] activate_level_i,
	// Position commands, pan, tilt, focus
	input wire [15:0] pan_command_i,
	input wire [15:0] tilt_command_i,
	input wire [15:0] focus_command_i,
	// Limited position targets
	output reg [15:0] pan_target_o,
	output reg [15:0] tilt_target_o,
	output reg [15:0] focus_target_o,
	// Recalibration request
	output reg recal_focus_o,
	// Avalon-MM slave
	input wire [7:0] address_i,
	input wire read_i,
	input wire write_i,
	input wire [31:0] writedata_i,
	input wire [3:0] byteenable_i,
	output reg [31:0] readdata_o,
	output reg waitrequest_o
);

	localparam NPAR = 9;

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	reg rst_q1;
	reg rst_q2;
	always @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_q1 <= 1'b0;
			rst_q2 <= 1'b0;
		end else begin
			rst_q1 <= 1'b1;
			rst_q2 <= rst_q1;
		end
	end

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	// 0 none, 1..6 limit (axis*2 + upper + 1), 7 focus recalibration
	function [2:0] decode_control;
		input [7:0] lvl;
		begin
			if (lvl < `LVL_PAN_MIN_LO)
				decode_control = 3'h0;
			else if (lvl < `LVL_PAN_MAX_LO)
				decode_control = 3'h1;
			else if (lvl < `LVL_TILT_MIN_LO)
				decode_control = 3'h2;
			else if (lvl < `LVL_TILT_MAX_LO)
				decode_control = 3'h3;
			else if (lvl < `LVL_FOCUS_MIN_LO)
				decode_control = 3'h4;
			else if (lvl < `LVL_FOCUS_MAX_LO)
				decode_control = 3'h5;
			else if (lvl <= `LVL_FOCUS_MAX_HI)
				decode_control = 3'h6;
			else if (lvl >= `LVL_RECAL_FOCUS_LO &&
				lvl <= `LVL_RECAL_FOCUS_HI)
				decode_control = 3'h7;
			else
				decode_control = 3'h0;
		end
	endfunction

	function [15:0] merge_bytes;
		input [15:0] old;
		input [31:0] wd;
		input [3:0] be;
		begin
			merge_bytes[7:0] = be[0] ? wd[7:0] : old[7:0];
			merge_bytes[15:8] = be[1] ? wd[15:8] : old[15:8];
		end
	endfunction

	// ----------------------------------------
	// Command widening, byte mode replicates
	// ----------------------------------------
	reg [7:0] mode_q;
	wire [15:0] raw_cmd [0:2];
	wire [15:0] cmd [0:2];
	assign raw_cmd[0] = pan_command_i;
	assign raw_cmd[1] = tilt_command_i;
	assign raw_cmd[2] = focus_command_i;

	genvar g;
	generate
		for (g = 0; g < AXES; g = g + 1) begin : widen
			assign cmd[g] = mode_q[`MODE_BYTE_LSB + g] ?
				{raw_cmd[g][7:0], raw_cmd[g][7:0]} : raw_cmd[g];
		end
	endgenerate

	// ----------------------------------------
	// Hold qualification
	// ----------------------------------------
	wire fire;
	wire fire_reset;
	wire [7:0] fire_control;
	wire armed;

	hold_qualifier #(
		.HOLD_CYCLES(HOLD_CYCLES)
	) u_hold (
		.clock_i(clock_i),
		.rst_b_i(rst_q2),
		.control_level_i(control_level_i),
		.activate_level_i(activate_level_i),
		.fire_o(fire),
		.fire_reset_o(fire_reset),
		.fire_control_o(fire_control),
		.armed_o(armed)
	);

	wire [2:0] fire_cmd;
	wire [2:0] lim_code;
	wire [1:0] lim_axis;
	wire [3:0] lim_index;
	wire lim_fire;
	assign fire_cmd = decode_control(fire_control);
	assign lim_code = fire_cmd - 3'h1;
	assign lim_axis = lim_code[2:1];
	assign lim_index = {2'b00, lim_axis} * 4'h3 + {3'b000, lim_code[0]};
	assign lim_fire = fire && fire_cmd != 3'h0 && fire_cmd != 3'h7;

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	wire take;
	wire wr;
	wire [7:0] ofs;
	wire [7:0] par_ofs;
	wire par_hit;
	wire [3:0] par_index;
	assign take = (read_i || write_i) && !waitrequest_o;
	assign wr = write_i && !waitrequest_o;
	assign ofs = {address_i[7:2], 2'b00};
	assign par_ofs = ofs - `OFS_PARAM_BASE;
	assign par_hit = ofs >= `OFS_PARAM_BASE &&
		par_ofs[7:2] < NPAR;
	assign par_index = par_ofs[5:2];

	// ----------------------------------------
	// Parameter store and local editing
	// ----------------------------------------
	// Index axis*3 + 0 lower, 1 upper, 2 home
	reg [15:0] param_q [0:NPAR-1];
	reg [3:0] edit_sel_q;
	reg [15:0] edit_val_q;
	reg [2:0] last_cmd_q;
	wire key_wr;
	wire [15:0] key;
	assign key_wr = wr && ofs == `OFS_EDIT_KEY && byteenable_i[0];
	assign key = writedata_i[15:0];

	integer i;
	always @(posedge clock_i or negedge rst_q2) begin
		if (!rst_q2) begin
			for (i = 0; i < NPAR; i = i + 1) begin
				if (i % 3 == 0)
					param_q[i] <= `LOWER_RESET;
				else if (i % 3 == 1)
					param_q[i] <= `UPPER_RESET;
				else
					param_q[i] <= `HOME_RESET;
			end
			edit_sel_q <= 4'h0;
			edit_val_q <= `LOWER_RESET;
			mode_q <= `MODE_RESET;
			last_cmd_q <= 3'h0;
		end else begin
			if (wr && ofs == `OFS_MODE && byteenable_i[0])
				mode_q <= writedata_i[7:0];
			if (wr && ofs == `OFS_EDIT_SEL && byteenable_i[0] &&
				writedata_i[3:0] < NPAR) begin
				edit_sel_q <= writedata_i[3:0];
				edit_val_q <= param_q[writedata_i[3:0]];
			end else if (wr && ofs == `OFS_EDIT_VALUE) begin
				edit_val_q <= merge_bytes(edit_val_q, writedata_i,
					byteenable_i);
			end else if (key_wr) begin
				if (key[`KEY_COARSE_DEC])
					edit_val_q <= edit_val_q - `COARSE_STEP;
				else if (key[`KEY_FINE_DEC])
					edit_val_q <= edit_val_q - `FINE_STEP;
				else if (key[`KEY_FINE_INC])
					edit_val_q <= edit_val_q + `FINE_STEP;
				else if (key[`KEY_COARSE_INC])
					edit_val_q <= edit_val_q + `COARSE_STEP;
			end
			if (key_wr && key[`KEY_ACCEPT])
				param_q[edit_sel_q] <= edit_val_q;
			// Console command wins over a local accept on the same word
			if (lim_fire) begin
				last_cmd_q <= fire_cmd;
				if (fire_reset)
					param_q[lim_index] <= lim_code[0] ?
						`UPPER_RESET : `LOWER_RESET;
				else
					param_q[lim_index] <= cmd[lim_axis];
			end else if (fire) begin
				last_cmd_q <= fire_cmd;
			end
		end
	end

	// ----------------------------------------
	// Limiting
	// ----------------------------------------
	wire [15:0] target [0:2];
	generate
		for (g = 0; g < AXES; g = g + 1) begin : lim
			position_limiter u_lim (
				.clock_i(clock_i),
				.rst_b_i(rst_q2),
				.command_i(cmd[g]),
				.lower_i(param_q[g * 3]),
				.upper_i(param_q[g * 3 + 1]),
				.rescale_i(mode_q[`MODE_RESCALE_LSB + g]),
				.target_o(target[g])
			);
		end
	endgenerate

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	always @(posedge clock_i or negedge rst_q2) begin
		if (!rst_q2) begin
			pan_target_o <= 16'h0000;
			tilt_target_o <= 16'h0000;
			focus_target_o <= 16'h0000;
			recal_focus_o <= 1'b0;
		end else begin
			pan_target_o <= target[0];
			tilt_target_o <= target[1];
			focus_target_o <= target[2];
			recal_focus_o <= fire && !fire_reset &&
				fire_cmd == 3'h7;
		end
	end

	// ----------------------------------------
	// Avalon slave: one wait cycle per access
	// ----------------------------------------
	reg [31:0] rd_d;
	always @* begin
		rd_d = 32'h00000000;
		if (ofs == `OFS_MODE)
			rd_d = {24'h000000, mode_q};
		else if (ofs == `OFS_STATUS)
			rd_d = {24'h000000, 1'b0, last_cmd_q, 3'b000, armed};
		else if (ofs == `OFS_EDIT_SEL)
			rd_d = {28'h0000000, edit_sel_q};
		else if (ofs == `OFS_EDIT_VALUE)
			rd_d = {16'h0000, edit_val_q};
		else if (par_hit)
			rd_d = {16'h0000, param_q[par_index]};
	end

	always @(posedge clock_i or negedge rst_q2) begin
		if (!rst_q2) begin
			waitrequest_o <= 1'b1;
			readdata_o <= 32'h00000000;
		end else begin
			if (take)
				waitrequest_o <= 1'b1;
			else if (read_i || write_i)
				waitrequest_o <= 1'b0;
			if (read_i && waitrequest_o)
				readdata_o <= rd_d;
		end
	end

endmodule // dmx_axis_limit_command_decoder

// ---- rtl/hold_qualifier.v ----
// Activate-level hold timer issuing one action per qualified hold
`include "dmx_limit_regs.vh"

module hold_qualifier #(
	parameter HOLD_CYCLES = `HOLD_CYCLES,
	parameter CW = 25
) (
	// Clock and reset
	input wire clock_i,
	input wire rst_b_i,
	// Channel levels
	input wire [7:0] control_level_i,
	input wire [7:0] activate_level_i,
	// Qualified action
	output reg fire_o,
	output reg fire_reset_o,
	output reg [7:0] fire_control_o,
	output reg armed_o
);

	reg [7:0] ctrl_q;
	reg [7:0] act_q;
	reg [CW-1:0] count_q;
	wire is_normal;
	wire is_reset;
	wire is_activate;
	wire changed;

	assign is_normal = (activate_level_i <= `LVL_NORMAL_HI);
	assign is_reset = (activate_level_i == `LVL_RESET);
	assign is_activate = (activate_level_i >= `LVL_ACTIVATE_LO);
	assign changed = (ctrl_q != control_level_i) ||
		(act_q != activate_level_i);

	always @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ctrl_q <= 8'h00;
			act_q <= 8'h00;
			count_q <= {CW{1'b0}};
			armed_o <= 1'b1;
			fire_o <= 1'b0;
			fire_reset_o <= 1'b0;
			fire_control_o <= 8'h00;
		end else begin
			ctrl_q <= control_level_i;
			act_q <= activate_level_i;
			fire_o <= 1'b0;
			if (changed || !(is_reset || is_activate)) begin
				count_q <= {CW{1'b0}};
			end else if (count_q != HOLD_CYCLES[CW-1:0]) begin
				count_q <= count_q + 1'b1;
			end
			if (is_normal) begin
				armed_o <= 1'b1;
			end else if (armed_o && !changed &&
				count_q == HOLD_CYCLES[CW-1:0] - 1'b1) begin
				armed_o <= 1'b0;
				fire_o <= 1'b1;
				fire_reset_o <= is_reset;
				fire_control_o <= control_level_i;
			end
		end
	end

endmodule // hold_qualifier

// ---- rtl/position_limiter.v ----
// Applies soft limits to one axis by rescaling or by holding the last in-range command
module position_limiter (
	// Clock and reset
	input wire clock_i,
	input wire rst_b_i,
	// Command and limits
	input wire [15:0] command_i,
	input wire [15:0] lower_i,
	input wire [15:0] upper_i,
	input wire rescale_i,
	// Limited target
	output reg [15:0] target_o
);

	wire [15:0] span;
	wire [32:0] product;
	wire [15:0] scaled;

	assign span = (upper_i > lower_i) ? (upper_i - lower_i) : 16'h0000;
	// Span times command, plus span, lands exactly on the limits at ends
	assign product = ({17'h00000, span} * {17'h00000, command_i}) +
		{17'h00000, span};
	assign scaled = lower_i + product[31:16];

	always @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			target_o <= 16'h0000;
		end else if (rescale_i) begin
			target_o <= scaled;
		end else if (command_i >= lower_i && command_i <= upper_i) begin
			target_o <= command_i;
		end
	end

endmodule // position_limiter

// ---- testbench/dmx_axis_limit_command_decoder_tb.sv ----
// Self-checking bench for the DMX axis limit command decoder
`include "dmx_limit_regs.vh"

module dmx_axis_limit_command_decoder_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int HOLD_CYCLES = 20;
	localparam int FULL = HOLD_CYCLES + 6;
	localparam logic [31:0] RST [3] = '{32'h0, 32'hFFFF, 32'h8000};
	localparam logic [7:0] MD [10] = '{8'h01, 8'h01, 8'h01, 8'h11, 8'h11,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	localparam logic [15:0] CM [10] = '{16'h0000, 16'hFFFF, 16'h8000,
		16'h00FF, 16'hAB00, 16'h5000, 16'h2000, 16'hC000, 16'h4000, 16'hBFFF};
	localparam logic [15:0] TG [10] = '{16'h4000, 16'hBFFF, 16'h7FFF,
		16'hBFFF, 16'h4000, 16'h5000, 16'h5000, 16'h5000, 16'h4000, 16'hBFFF};
	localparam logic [7:0] RC [6] = '{8'h8C, 8'h98, 8'h8C, 8'h99, 8'h8B, 8'h8C};
	localparam logic [7:0] RA [6] = '{8'hFF, 8'hFF, 8'h82, 8'hFF, 8'hFF, 8'hE5};
	localparam logic [31:0] RN [6] = '{32'h1, 32'h2, 32'h2, 32'h2, 32'h2, 32'h2};
	localparam int KY [5] = '{3, 2, 2, 1, 0};
	localparam logic [31:0] KV [5] = '{32'h8100, 32'h8101, 32'h8102,
		32'h8101, 32'h8001};
	logic clock_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic [7:0] control_level_i;
	logic [7:0] activate_level_i;
	logic [15:0] pan_command_i = 16'h0000;
	logic [15:0] tilt_command_i = 16'h0000;
	logic [15:0] focus_command_i = 16'h0000;
	logic [15:0] pan_target_o;
	logic [15:0] tilt_target_o;
	logic [15:0] focus_target_o;
	logic recal_focus_o;
	logic [7:0] address_i = 8'h00;
	logic read_i = 1'b0;
	logic write_i = 1'b0;
	logic [31:0] writedata_i = 32'h0;
	logic [3:0] byteenable_i = 4'hF;
	logic [31:0] readdata_o;
	logic waitrequest_o;
	logic [31:0] rd;
	int miscompares = 0;
	int samples_checked = 0;
	int recal_seen = 0;

	always #25 clock_i = ~clock_i;
	always @(posedge clock_i)
		if (recal_focus_o === 1'b1)
			recal_seen++;

	dmx_console i_dmx_console (.clock_i(clock_i),
		.control_level_o(control_level_i),
		.activate_level_o(activate_level_i));
	dmx_axis_limit_command_decoder #(
		.HOLD_CYCLES(HOLD_CYCLES)
	) i_dmx_axis_limit_command_decoder (
		.clock_i(clock_i), .rst_b_i(rst_b_i),
		.control_level_i(control_level_i),
		.activate_level_i(activate_level_i),
		.pan_command_i(pan_command_i), .tilt_command_i(tilt_command_i),
		.focus_command_i(focus_command_i), .pan_target_o(pan_target_o),
		.tilt_target_o(tilt_target_o), .focus_target_o(focus_target_o),
		.recal_focus_o(recal_focus_o), .address_i(address_i),
		.read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
		.byteenable_i(byteenable_i), .readdata_o(readdata_o),
		.waitrequest_o(waitrequest_o));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Holds the request until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] wd);
		address_i <= a;
		writedata_i <= wd;
		write_i <= wr;
		read_i <= !wr;
		do begin
			@(posedge clock_i);
		end while (waitrequest_o !== 1'b0);
		rd = readdata_o;
		read_i <= 1'b0;
		write_i <= 1'b0;
		@(posedge clock_i);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check(rd, exp);
	endtask
	task automatic tally_and_finish();
		$display("checked=%0d miscompares=%0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clock_i);
		miscompares++;
		tally_and_finish();
	end

	initial begin
		repeat (3) @(posedge clock_i);
		rst_b_i <= 1'b1;
		repeat (5) @(posedge clock_i);
		for (int k = 0; k < 9; k++)
			rd_chk(`OFS_PARAM_BASE + 8'(4 * k), RST[k % 3]);
		rd_chk(`OFS_MODE, 32'h0);
		rd_chk(8'h1C, 32'h0);
		bus(1'b1, `OFS_PARAM_BASE, 32'h1234);
		rd_chk(`OFS_PARAM_BASE, 32'h0);
		pan_command_i <= 16'h4000;
		i_dmx_console.command(8'h33, 8'hFF, FULL);
		rd_chk(`OFS_PARAM_BASE, 32'h4000);
		rd_chk(`OFS_STATUS, 32'h11);
		pan_command_i <= 16'hBFFF;
		i_dmx_console.command(8'h4C, 8'hFF, FULL);
		rd_chk(`OFS_PARAM_BASE + 8'h04, 32'hBFFF);
		pan_command_i <= 16'h1000;
		i_dmx_console.command(8'h32, 8'hFF, FULL);
		rd_chk(`OFS_PARAM_BASE, 32'h4000);
		// Short holds, and a level change inside a hold
		i_dmx_console.command(8'h33, 8'hFF, HOLD_CYCLES - 4);
		i_dmx_console.level(8'h33, 8'hFF, HOLD_CYCLES - 4);
		i_dmx_console.level(8'h33, 8'hF0, HOLD_CYCLES - 4);
		i_dmx_console.level(8'h33, 8'h00, 3);
		rd_chk(`OFS_PARAM_BASE, 32'h4000);
		pan_command_i <= 16'h3000;
		i_dmx_console.level(8'h3E, 8'h00, 2);
		i_dmx_console.level(8'h3E, 8'hFF, FULL);
		pan_command_i <= 16'h3800;
		i_dmx_console.level(8'h3E, 8'hFF, FULL);
		i_dmx_console.level(8'h3E, 8'h00, 3);
		rd_chk(`OFS_PARAM_BASE, 32'h3000);
		i_dmx_console.command(8'h33, 8'h82, FULL);
		rd_chk(`OFS_PARAM_BASE, 32'h0);
		rd_chk(`OFS_PARAM_BASE + 8'h04, 32'hBFFF);
		pan_command_i <= 16'h4000;
		i_dmx_console.command(8'h33, 8'hFF, FULL);
		for (int k = 0; k < 10; k++) begin
			bus(1'b1, `OFS_MODE, {24'h0, MD[k]});
			pan_command_i <= CM[k];
			repeat (3) @(posedge clock_i);
			check({16'h0, pan_target_o}, {16'h0, TG[k]});
		end
		i_dmx_console.command(8'h3F, 8'h82, FULL);
		rd_chk(`OFS_PARAM_BASE + 8'h04, 32'hFFFF);
		for (int k = 0; k < 6; k++) begin
			i_dmx_console.command(RC[k], RA[k], FULL);
			check(32'(recal_seen), RN[k]);
		end
		bus(1'b1, `OFS_EDIT_SEL, 32'h2);
		rd_chk(`OFS_EDIT_VALUE, 32'h8000);
		for (int k = 0; k < 5; k++) begin
			bus(1'b1, `OFS_EDIT_KEY, 32'h1 << KY[k]);
			rd_chk(`OFS_EDIT_VALUE, KV[k]);
		end
		bus(1'b1, `OFS_EDIT_KEY, 32'h10);
		rd_chk(`OFS_PARAM_BASE + 8'h08, 32'h8001);
		// Tilt minimum capture, then tilt target holds on a command below it, focus passes through
		tilt_command_i <= 16'h2000;
		focus_command_i <= 16'hFEDC;
		i_dmx_console.command(8'h4D, 8'hFF, FULL);
		rd_chk(`OFS_PARAM_BASE + 8'h0C, 32'h2000);
		rd_chk(`OFS_STATUS, 32'h31);
		tilt_command_i <= 16'h1000;
		repeat (3) @(posedge clock_i);
		check({16'h0, tilt_target_o}, 32'h2000);
		check({16'h0, focus_target_o}, 32'hFEDC);
		tally_and_finish();
	end
endmodule // dmx_axis_limit_command_decoder_tb

bind dmx_axis_limit_command_decoder dmx_limit_properties #(
	.HOLD_CYCLES(HOLD_CYCLES)
) i_dmx_limit_properties (
	.clock_i(clock_i), .rst_b_i(rst_b_i),
	.control_level_i(control_level_i),
	.activate_level_i(activate_level_i),
	.recal_focus_o(recal_focus_o), .read_i(read_i), .write_i(write_i),
	.readdata_o(readdata_o), .waitrequest_o(waitrequest_o));

// ---- testbench/dmx_console.sv ----
// Console model driving the control and activate channel levels
module dmx_console (
	// Clock
	input wire logic clock_i,
	// Channel levels
	output logic [7:0] control_level_o,
	output logic [7:0] activate_level_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		control_level_o = 8'h00;
		activate_level_o = 8'h00;
	end
	task automatic level(input logic [7:0] ctl, input logic [7:0] act,
		input int n);
		control_level_o <= ctl;
		activate_level_o <= act;
		repeat (n) @(posedge clock_i);
	endtask
	// Control first, activate held, then back to normal
	task automatic command(input logic [7:0] ctl, input logic [7:0] act,
		input int hold);
		level(ctl, 8'h00, 2);
		level(ctl, act, hold);
		level(ctl, 8'h00, 3);
	endtask
	// Setups are never saved here: keeping limits is optional
endmodule // dmx_console

// ---- testbench/dmx_limit_properties.sv ----
// Concurrent checks on the limit decoder ports
module dmx_limit_properties #(
	parameter HOLD_CYCLES = 20
) (
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic [7:0] control_level_i,
	input wire logic [7:0] activate_level_i,
	input wire logic recal_focus_o,
	input wire logic read_i,
	input wire logic write_i,
	input wire logic [31:0] readdata_o,
	input wire logic waitrequest_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [31:0] steady_q;
	logic [7:0] ctl_q;
	logic [7:0] act_q;
	logic rearm_q;
	logic recal_lvl;
	assign recal_lvl = control_level_i >= 8'h8C && control_level_i <= 8'h98
		&& activate_level_i >= 8'hE6;
	// ----
	// Level steadiness and rearm tracking
	// ----
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			steady_q <= 32'h0;
			ctl_q <= 8'h00;
			act_q <= 8'h00;
			rearm_q <= 1'b1;
		end else begin
			ctl_q <= control_level_i;
			act_q <= activate_level_i;
			if (control_level_i != ctl_q || activate_level_i != act_q)
				steady_q <= 32'h0;
			else if (steady_q != 32'hFFFFFFFF)
				steady_q <= steady_q + 32'h1;
			if (recal_focus_o)
				rearm_q <= 1'b0;
			else if (activate_level_i <= 8'h09)
				rearm_q <= 1'b1;
		end
	end
	// ----
	// Properties
	// ----
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_b_i);
	sequence s_req_wait;
		(read_i || write_i) && waitrequest_o;
	endsequence
	sequence s_answer;
		!waitrequest_o ##1 waitrequest_o;
	endsequence
	AST_WAIT_ONE: assert property (s_req_wait |=> s_answer)
		else $error("bus answer not one cycle after request");
	AST_IDLE_WAIT: assert property (!(read_i || write_i) |=> waitrequest_o)
		else $error("waitrequest low without request");
	AST_READ_HOLD: assert property (!read_i |=> $stable(readdata_o))
		else $error("read data changed without read");
	AST_UPPER_ZERO: assert property (
		read_i && !waitrequest_o |-> readdata_o[31:16] == 16'h0000)
		else $error("upper read bits not zero");
	AST_RECAL_PULSE: assert property (recal_focus_o |=> !recal_focus_o)
		else $error("recal pulse longer than one cycle");
	AST_RECAL_LEVELS: assert property (recal_focus_o |-> recal_lvl)
		else $error("recal without recal levels");
	AST_RECAL_HOLD: assert property (
		recal_focus_o |-> steady_q >= HOLD_CYCLES - 2)
		else $error("recal before hold time");
	AST_RECAL_ONCE: assert property (recal_focus_o |-> rearm_q)
		else $error("recal repeated within one hold");
	AST_RECAL_SOON: assert property (
		recal_lvl && steady_q == HOLD_CYCLES + 4 |-> !rearm_q)
		else $error("recal missing after hold");
endmodule // dmx_limit_properties
